// ---- rtl/tdm_port_pkg.sv ----
// Shared constants for the TDM port framing control block
package tdm_port_pkg;

    // ****************************
    // Register map
    // ****************************
    localparam logic [7:0] RX_CTRL_OFS = 8'h00;
    localparam logic [7:0] TX_CTRL_OFS = 8'h04;
    localparam logic [15:0] RX_CTRL_RESET = 16'h0000;
    localparam logic [15:0] TX_CTRL_RESET = 16'h0000;
    localparam logic [15:0] RX_WR_MASK = 16'h47FF;
    localparam logic [15:0] TX_WR_MASK = 16'h4FFF;
    localparam logic [15:0] FAST_MASK = 16'h0100;

    // ****************************
    // Field positions
    // ****************************
    localparam int CTL_CLK_INV = 0;
    localparam int CTL_DATA_INV = 1;
    localparam int CTL_SYNC_INV = 2;
    localparam int RX_DET_RST = 3;
    localparam int TX_FORCE_N = 3;
    localparam int CTL_SYNC_DLY = 4;
    localparam int CTL_FRAME_SIZE = 6;
    localparam int CTL_FAST = 8;
    localparam int CTL_UNCHAN = 9;
    localparam int CTL_LOOP = 10;
    localparam int TX_PSEL = 11;
    localparam int RX_TIMEOUT = 12;
    localparam int RX_LOOP_UP = 13;
    localparam int CTL_IRQ_EN = 14;
    localparam int CTL_FLAG = 15;

    // ****************************
    // Frame timing, in line clocks
    // ****************************
    localparam logic [9:0] T1_LAST = 10'h0C0;
    localparam logic [9:0] E1_LAST = 10'h0FF;
    localparam logic [9:0] M4_LAST = 10'h1FF;
    localparam logic [9:0] M8_LAST = 10'h3FF;

    typedef enum logic [1:0] {
        DET_IDLE = 2'b01,
        DET_ARMED = 2'b10
    } det_state_e;

    function automatic logic [9:0] frame_last(input logic [1:0] size);
        case (size)
            2'b00: frame_last = T1_LAST;
            2'b01: frame_last = E1_LAST;
            2'b10: frame_last = M4_LAST;
            default: frame_last = M8_LAST;
        endcase
    endfunction

    // Whole-clock lead of the sync; half-clock lead uses the other edge
    function automatic logic [1:0] sync_lead(input logic [1:0] dly);
        case (dly)
            2'b10: sync_lead = 2'h1;
            2'b11: sync_lead = 2'h2;
            default: sync_lead = 2'h0;
        endcase
    endfunction

endpackage

// ---- rtl/line_sample_if.sv ----
// Configuration and sampled results between the port controller and a line framer
`timescale 1ns/1ps
interface line_sample_if;
    logic clk_inv;
    logic data_inv;
    logic sync_inv;
    logic [1:0] sync_delay;
    logic [1:0] frame_size;
    logic unchan;
    logic bit_stb;
    logic data_bit;
    logic frame_start;
    logic align_change;
    logic [9:0] bit_index;

    modport framer (
        input clk_inv, data_inv, sync_inv, sync_delay, frame_size, unchan,
        output bit_stb, data_bit, frame_start, align_change, bit_index
    );
    modport user (
        output clk_inv, data_inv, sync_inv, sync_delay, frame_size, unchan,
        input bit_stb, data_bit, frame_start, align_change, bit_index
    );
endinterface

// ---- rtl/line_framer.sv ----
// Line pin synchroniser, edge finder and frame alignment tracker
`timescale 1ns/1ps
module line_framer (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic line_clk_i,
    input wire logic line_data_i,
    input wire logic line_sync_i,
    line_sample_if.framer ls
);
    // ****************************
    // Pin synchronisers
    // ****************************
    logic [2:0] clk_s_q, dat_s_q, syn_s_q;
    logic clk_f_q, dat_f_q, syn_f_q, clk_prev_q;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            clk_s_q <= 3'h0;
            dat_s_q <= 3'h0;
            syn_s_q <= 3'h0;
            clk_f_q <= 1'b0;
            dat_f_q <= 1'b0;
            syn_f_q <= 1'b0;
            clk_prev_q <= 1'b0;
        end else begin
            clk_s_q <= {clk_s_q[1:0], line_clk_i};
            dat_s_q <= {dat_s_q[1:0], line_data_i};
            syn_s_q <= {syn_s_q[1:0], line_sync_i};
            // A level counts only once the second and third stages agree
            if (clk_s_q[1] == clk_s_q[2]) clk_f_q <= clk_s_q[2];
            if (dat_s_q[1] == dat_s_q[2]) dat_f_q <= dat_s_q[2];
            if (syn_s_q[1] == syn_s_q[2]) syn_f_q <= syn_s_q[2];
            clk_prev_q <= clk_f_q;
        end
    end

    // ****************************
    // Edges and sync sensing
    // ****************************
    logic rise, fall, stb, half, sync_lvl, seen, ev, start_now;
    logic sync_half_q, seen_prev_q, locked_q;
    logic [1:0] lead, cd_q;
    logic [9:0] cnt_q, last, cnt_next;

    assign rise = clk_f_q & ~clk_prev_q;
    assign fall = ~clk_f_q & clk_prev_q;
    assign stb = ls.clk_inv ? fall : rise;
    assign half = ls.clk_inv ? rise : fall;
    assign sync_lvl = syn_f_q ^ ls.sync_inv;
    assign seen = (ls.sync_delay == 2'b01) ? sync_half_q : sync_lvl;
    assign ev = stb & seen & ~seen_prev_q & ~ls.unchan;
    assign lead = tdm_port_pkg::sync_lead(ls.sync_delay);
    assign start_now = stb & ((ev & (lead == 2'h0)) | (cd_q == 2'h1));
    assign last = tdm_port_pkg::frame_last(ls.frame_size);
    assign cnt_next = (cnt_q == last) ? 10'h000 : cnt_q + 10'h001;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sync_half_q <= 1'b0;
            seen_prev_q <= 1'b0;
        end else begin
            if (half) sync_half_q <= sync_lvl;
            if (stb) seen_prev_q <= seen;
        end
    end

    // ****************************
    // Frame counter
    // ****************************
    always_ff @(posedge clk_i) begin
        if (rst_i || ls.unchan) begin
            cnt_q <= 10'h000;
            cd_q <= 2'h0;
            locked_q <= 1'b0;
        end else if (stb) begin
            if (ev && lead != 2'h0) cd_q <= lead;
            else if (cd_q != 2'h0) cd_q <= cd_q - 2'h1;
            if (start_now) begin
                cnt_q <= 10'h000;
                locked_q <= 1'b1;
            end else begin
                cnt_q <= cnt_next;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ls.bit_stb <= 1'b0;
            ls.data_bit <= 1'b0;
            ls.frame_start <= 1'b0;
            ls.align_change <= 1'b0;
            ls.bit_index <= 10'h000;
        end else begin
            ls.bit_stb <= stb;
            if (stb) ls.data_bit <= dat_f_q ^ ls.data_inv;
            if (stb) ls.bit_index <= start_now ? 10'h000 : cnt_next;
            ls.frame_start <= stb & ~ls.unchan & (start_now | (locked_q & cnt_next == 10'h000));
            // Sync on any bit but the first of the running frame
            ls.align_change <= start_now & locked_q & (cnt_next != 10'h000);
        end
    end

    // ****************************
    // Checks
    // ****************************
    a_frame_wrap:
    assert property (@(posedge clk_i) disable iff (rst_i)
        stb && !start_now && !ls.unchan && cnt_q == last |=> ls.bit_index == 10'h000)
        else $error("frame counter did not wrap at frame end");

    a_lead_two:
    assert property (@(posedge clk_i) disable iff (rst_i)
        ev && ls.sync_delay == 2'b11 |=> cd_q == 2'h2)
        else $error("two-clock sync lead not loaded");

endmodule

// ---- rtl/tdm_port_framing_control.sv ----
// Per-port receive and transmit framing control with classic Wishbone registers
//
// The Wishbone interface to the registers and the register offsets were decided locally.
`timescale 1ns/1ps
module tdm_port_framing_control #(
    parameter int PORT_INDEX = 0
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic rx_clock_pin_i,
    input wire logic rx_data_pin_i,
    input wire logic rx_frame_sync_pin_i,
    input wire logic tx_clock_pin_i,
    input wire logic tx_frame_sync_pin_i,
    output logic tx_data_pin_o,
    output logic rx_bit_o,
    output logic rx_bit_valid_o,
    output logic rx_frame_start_o,
    output logic [9:0] rx_bit_index_o,
    output logic fast_rx_valid_o,
    output logic tx_bit_req_o,
    output logic fast_tx_req_o,
    output logic tx_frame_start_o,
    output logic [9:0] tx_bit_index_o,
    input wire logic hdlc_tx_bit_i,
    input wire logic bert_tx_bit_i,
    input wire logic fast_tx_bit_i,
    input wire logic tx_timeslot_enable_i,
    input wire logic tx_timeslot_pattern_select_i,
    output logic loop_detector_reset_o,
    input wire logic loop_up_seen_i,
    input wire logic loop_down_seen_i,
    input wire logic loop_search_done_i,
    output logic irq_o
);
    // ****************************
    // Control registers
    // ****************************
    // Fast bypass bit exists only on the two fast-capable ports
    localparam logic [15:0] FAST_KEEP = (PORT_INDEX < 2) ? 16'hFFFF : ~tdm_port_pkg::FAST_MASK;
    localparam logic [15:0] RX_MASK = tdm_port_pkg::RX_WR_MASK & FAST_KEEP;
    localparam logic [15:0] TX_MASK = tdm_port_pkg::TX_WR_MASK & FAST_KEEP;

    logic [15:0] rx_ctl_q, tx_ctl_q, rx_rd, tx_rd;
    logic ack_q, req, wr_take, rd_clr_rx, rd_clr_tx, hit_rx, hit_tx;
    logic rx_flag_q, tx_flag_q, loop_up_q;
    logic [31:0] dat_q;

    function automatic logic [15:0] merge_write(
        input logic [15:0] old,
        input logic [31:0] wdat,
        input logic [3:0] sel,
        input logic [15:0] mask
    );
        logic [15:0] m;
        m = mask & {{8{sel[1]}}, {8{sel[0]}}};
        merge_write = (old & ~m) | (wdat[15:0] & m);
    endfunction

    assign req = wb_cyc_i & wb_stb_i;
    assign hit_rx = wb_adr_i == tdm_port_pkg::RX_CTRL_OFS;
    assign hit_tx = wb_adr_i == tdm_port_pkg::TX_CTRL_OFS;
    assign wr_take = req & ack_q & wb_we_i;
    assign rd_clr_rx = req & ack_q & ~wb_we_i & hit_rx;
    assign rd_clr_tx = req & ack_q & ~wb_we_i & hit_tx;
    assign wb_ack_o = ack_q;
    assign wb_dat_o = dat_q;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rx_ctl_q <= tdm_port_pkg::RX_CTRL_RESET;
            tx_ctl_q <= tdm_port_pkg::TX_CTRL_RESET;
        end else if (wr_take) begin
            if (hit_rx) rx_ctl_q <= merge_write(rx_ctl_q, wb_dat_i, wb_sel_i, RX_MASK);
            if (hit_tx) tx_ctl_q <= merge_write(tx_ctl_q, wb_dat_i, wb_sel_i, TX_MASK);
        end
    end

    // Status in real time; flags and loop-up come from the block's own state
    always_comb begin
        rx_rd = rx_ctl_q;
        rx_rd[tdm_port_pkg::RX_TIMEOUT] = loop_search_done_i & ~loop_up_q;
        rx_rd[tdm_port_pkg::RX_LOOP_UP] = loop_up_q;
        rx_rd[tdm_port_pkg::CTL_FLAG] = rx_flag_q;
        tx_rd = tx_ctl_q;
        tx_rd[tdm_port_pkg::CTL_FLAG] = tx_flag_q;
    end

    // ****************************
    // Wishbone slave
    // ****************************
    // One wait state; unmapped addresses answer with zero data
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
            dat_q <= 32'h0000_0000;
        end else begin
            ack_q <= req & ~ack_q;
            if (req && !ack_q && !wb_we_i) begin
                dat_q <= 32'h0000_0000;
                if (hit_rx) dat_q <= {16'h0000, rx_rd};
                if (hit_tx) dat_q <= {16'h0000, tx_rd};
            end
        end
    end

    // ****************************
    // Line framers
    // ****************************
    line_sample_if rx_ls ();
    line_sample_if tx_ls ();

    assign rx_ls.clk_inv = rx_ctl_q[tdm_port_pkg::CTL_CLK_INV];
    assign rx_ls.data_inv = rx_ctl_q[tdm_port_pkg::CTL_DATA_INV];
    assign rx_ls.sync_inv = rx_ctl_q[tdm_port_pkg::CTL_SYNC_INV];
    assign rx_ls.sync_delay = rx_ctl_q[tdm_port_pkg::CTL_SYNC_DLY +: 2];
    assign rx_ls.frame_size = rx_ctl_q[tdm_port_pkg::CTL_FRAME_SIZE +: 2];
    assign rx_ls.unchan = rx_ctl_q[tdm_port_pkg::CTL_UNCHAN];
    assign tx_ls.clk_inv = tx_ctl_q[tdm_port_pkg::CTL_CLK_INV];
    assign tx_ls.data_inv = 1'b0;
    assign tx_ls.sync_inv = tx_ctl_q[tdm_port_pkg::CTL_SYNC_INV];
    assign tx_ls.sync_delay = tx_ctl_q[tdm_port_pkg::CTL_SYNC_DLY +: 2];
    assign tx_ls.frame_size = tx_ctl_q[tdm_port_pkg::CTL_FRAME_SIZE +: 2];
    assign tx_ls.unchan = tx_ctl_q[tdm_port_pkg::CTL_UNCHAN];

    line_framer u_rx_framer (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .line_clk_i(rx_clock_pin_i),
        .line_data_i(rx_data_pin_i),
        .line_sync_i(rx_frame_sync_pin_i),
        .ls(rx_ls.framer)
    );

    line_framer u_tx_framer (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .line_clk_i(tx_clock_pin_i),
        .line_data_i(1'b0),
        .line_sync_i(tx_frame_sync_pin_i),
        .ls(tx_ls.framer)
    );

    // ****************************
    // Transmit data path
    // ****************************
    logic tx_fast, tx_unchan, tx_psel, tx_src, tx_bit, tx_line_q;
    assign tx_fast = tx_ctl_q[tdm_port_pkg::CTL_FAST];
    assign tx_unchan = tx_ctl_q[tdm_port_pkg::CTL_UNCHAN];
    // Port-level select overrides the per-timeslot choice only when unchannelized
    assign tx_psel = tx_unchan ? tx_ctl_q[tdm_port_pkg::TX_PSEL]
                               : tx_timeslot_pattern_select_i;

    always_comb begin
        if (tx_fast) tx_src = fast_tx_bit_i;
        else if (!(tx_unchan || tx_timeslot_enable_i)) tx_src = 1'b1;
        else if (tx_psel) tx_src = bert_tx_bit_i;
        else tx_src = hdlc_tx_bit_i;
        // Network loopback sends the last received bit back out
        tx_bit = tx_ctl_q[tdm_port_pkg::CTL_LOOP] ? rx_ls.data_bit : tx_src;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tx_line_q <= 1'b1;
        end else if (tx_ls.bit_stb) begin
            // Forcing wins over inversion so the pin itself is all ones
            if (!tx_ctl_q[tdm_port_pkg::TX_FORCE_N]) tx_line_q <= 1'b1;
            else tx_line_q <= tx_bit ^ tx_ctl_q[tdm_port_pkg::CTL_DATA_INV];
        end
    end

    assign tx_data_pin_o = tx_line_q;
    assign tx_bit_req_o = tx_ls.bit_stb & ~tx_fast;
    assign fast_tx_req_o = tx_ls.bit_stb & tx_fast;
    assign tx_frame_start_o = tx_ls.frame_start & ~tx_fast;
    assign tx_bit_index_o = tx_ls.bit_index;

    // ****************************
    // Receive data path
    // ****************************
    logic rx_fast, local_lb, rx_src_stb, rx_src_bit;
    logic rx_bit_q, rx_valid_q, fast_valid_q, rx_fs_q;
    logic [9:0] rx_idx_q;
    assign rx_fast = rx_ctl_q[tdm_port_pkg::CTL_FAST];
    assign local_lb = rx_ctl_q[tdm_port_pkg::CTL_LOOP];
    assign rx_src_stb = local_lb ? tx_ls.bit_stb : rx_ls.bit_stb;
    assign rx_src_bit = local_lb ? tx_line_q : rx_ls.data_bit;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rx_bit_q <= 1'b0;
            rx_valid_q <= 1'b0;
            fast_valid_q <= 1'b0;
            rx_fs_q <= 1'b0;
            rx_idx_q <= 10'h000;
        end else begin
            if (rx_src_stb) rx_bit_q <= rx_src_bit;
            rx_valid_q <= rx_src_stb & ~rx_fast;
            fast_valid_q <= rx_src_stb & rx_fast;
            rx_fs_q <= ~rx_fast & (local_lb ? tx_ls.frame_start : rx_ls.frame_start);
            rx_idx_q <= local_lb ? tx_ls.bit_index : rx_ls.bit_index;
        end
    end

    assign rx_bit_o = rx_bit_q;
    assign rx_bit_valid_o = rx_valid_q;
    assign fast_rx_valid_o = fast_valid_q;
    assign rx_frame_start_o = rx_fs_q;
    assign rx_bit_index_o = rx_idx_q;

    // ****************************
    // Alignment flags and interrupt
    // ****************************
    logic irq_q;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rx_flag_q <= 1'b0;
            tx_flag_q <= 1'b0;
            irq_q <= 1'b0;
        end else begin
            // A new event beats a read clear in the same cycle
            if (rx_ls.align_change) rx_flag_q <= 1'b1;
            else if (rd_clr_rx) rx_flag_q <= 1'b0;
            if (tx_ls.align_change) tx_flag_q <= 1'b1;
            else if (rd_clr_tx) tx_flag_q <= 1'b0;
            irq_q <= (rx_flag_q & rx_ctl_q[tdm_port_pkg::CTL_IRQ_EN])
                   | (tx_flag_q & tx_ctl_q[tdm_port_pkg::CTL_IRQ_EN]);
        end
    end
    assign irq_o = irq_q;

    // ****************************
    // Loop detector control
    // ****************************
    tdm_port_pkg::det_state_e det_state_q;
    logic loop_detector_reset, det_pulse_q;
    assign loop_detector_reset = rx_ctl_q[tdm_port_pkg::RX_DET_RST];

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            det_state_q <= tdm_port_pkg::DET_IDLE;
            det_pulse_q <= 1'b0;
        end else begin
            det_pulse_q <= 1'b0;
            case (det_state_q)
                tdm_port_pkg::DET_IDLE: begin
                    if (loop_detector_reset) det_state_q <= tdm_port_pkg::DET_ARMED;
                end
                tdm_port_pkg::DET_ARMED: begin
                    if (!loop_detector_reset) begin
                        det_state_q <= tdm_port_pkg::DET_IDLE;
                        det_pulse_q <= 1'b1;
                    end
                end
                default: det_state_q <= tdm_port_pkg::DET_IDLE;
            endcase
        end
    end
    assign loop_detector_reset_o = det_pulse_q;

    always_ff @(posedge clk_i) begin
        if (rst_i) loop_up_q <= 1'b0;
        else if (loop_up_seen_i) loop_up_q <= 1'b1;
        else if (loop_down_seen_i || det_pulse_q) loop_up_q <= 1'b0;
    end

    // ****************************
    // Checks
    // ****************************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    a_force_ones_out:
    assert property (tx_ls.bit_stb && !tx_ctl_q[tdm_port_pkg::TX_FORCE_N] |=> tx_data_pin_o)
        else $error("transmit pin not forced to one");

    a_pattern_source:
    assert property (tx_ls.bit_stb && tx_ctl_q[tdm_port_pkg::TX_FORCE_N] && !tx_fast
        && tx_unchan && tx_ctl_q[tdm_port_pkg::TX_PSEL] && !tx_ctl_q[tdm_port_pkg::CTL_LOOP]
        && !tx_ctl_q[tdm_port_pkg::CTL_DATA_INV] |=> tx_data_pin_o == $past(bert_tx_bit_i))
        else $error("unchannelized pattern source not taken");

    a_rx_flag_set:
    assert property (rx_ls.align_change |=> rx_flag_q ##1 rx_flag_q || rd_clr_rx
        || $past(rd_clr_rx))
        else $error("receive alignment flag not latched");

    a_tx_flag_clear:
    assert property (rd_clr_tx && !tx_ls.align_change |=> !tx_flag_q)
        else $error("transmit alignment flag not cleared by read");

    a_irq_follows:
    assert property (rx_flag_q && rx_ctl_q[tdm_port_pkg::CTL_IRQ_EN] |=> irq_o)
        else $error("interrupt missing for enabled flag");

    a_det_pulse_cause:
    assert property (loop_detector_reset_o |-> $past(loop_detector_reset, 2) && !$past(loop_detector_reset))
        else $error("detector reset without rise and fall");

    a_loop_up_hold:
    assert property (loop_up_q && !loop_down_seen_i && !det_pulse_q |=> loop_up_q)
        else $error("loop-up status dropped early");

    a_timeout_read:
    assert property (rd_clr_rx && !$past(loop_up_q) |-> wb_dat_o[tdm_port_pkg::RX_TIMEOUT]
        == $past(loop_search_done_i))
        else $error("timeout status not reported");

    a_fast_route:
    assert property (rx_fast && rx_src_stb |=> fast_rx_valid_o && !rx_bit_valid_o)
        else $error("fast bypass did not reroute receive bits");

    a_local_loop:
    assert property (local_lb && tx_ls.bit_stb |=> rx_bit_valid_o || fast_rx_valid_o)
        else $error("local loopback lost a transmit bit");

    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("acknowledge held for two cycles");

    c_rx_align: cover property (rx_ls.align_change);
    c_det_reset: cover property (loop_detector_reset_o);
    c_unchan_bert: cover property (tx_bit_req_o && tx_unchan && tx_psel);
    c_flag_read: cover property (rd_clr_rx && rx_flag_q);

endmodule

// ---- test/line_partner.sv ----
// Line side model: link clock that runs only while enabled, level data, periodic sync
`timescale 1ns/1ps
module line_partner (
    input wire logic run_i,
    input wire logic level_i,
    input wire logic [10:0] frame_i,
    output logic clk_o,
    output logic data_o,
    output logic sync_o
);
    int pos = 0;
    initial clk_o = 1'b0;
    initial sync_o = 1'b0;
    // Stands still while run_i is low
    always #32 if (run_i) begin
        clk_o = ~clk_o;
        // Sync moves on the falling edge, clear of the sampling edge; zero length means no sync
        if (!clk_o) begin
            pos = (pos + 1 >= frame_i) ? 0 : pos + 1;
            sync_o = (frame_i != 11'h000) && (pos == 0);
        end
    end
    assign data_o = level_i;
endmodule

// ---- test/tb.sv ----
// Self-checking bench for the TDM port framing control block
`timescale 1ns/1ps
module tb;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0, we = 1'b0, hb = 1'b0, bb = 1'b0, run = 1'b0, lvl = 1'b0;
    logic up = 1'b0, dn = 1'b0, done = 1'b0, ack, txd, rxb, rxv, treq, lrst, lck, ldt, syn;
    logic irq, fs;
    logic [9:0] idx;
    logic [10:0] frame = 11'h000;
    logic [7:0] adr = 8'h00;
    logic [31:0] wd = 32'h0, rd, q, v, st = 32'h00018561;
    int bad_count = 0, comparisons = 0, n;
    always #2.5 clk_i = ~clk_i;
    line_partner lp (.run_i(run), .level_i(lvl), .frame_i(frame), .clk_o(lck), .data_o(ldt),
        .sync_o(syn));
    tdm_port_framing_control #(.PORT_INDEX(0)) dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
        .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h3), .wb_dat_i(wd),
        .wb_dat_o(rd), .wb_ack_o(ack), .rx_clock_pin_i(lck), .rx_data_pin_i(ldt),
        .rx_frame_sync_pin_i(syn), .tx_clock_pin_i(lck), .tx_frame_sync_pin_i(syn),
        .tx_data_pin_o(txd), .rx_bit_o(rxb), .rx_bit_valid_o(rxv), .rx_frame_start_o(fs),
        .rx_bit_index_o(idx), .fast_rx_valid_o(), .tx_bit_req_o(treq), .fast_tx_req_o(),
        .tx_frame_start_o(), .tx_bit_index_o(), .hdlc_tx_bit_i(hb), .bert_tx_bit_i(bb),
        .fast_tx_bit_i(1'b0), .tx_timeslot_pattern_select_i(1'b0),
        // Port memory written once and indirectly: every timeslot enabled
        .tx_timeslot_enable_i(1'b1),
        .loop_detector_reset_o(lrst), .loop_up_seen_i(up), .loop_down_seen_i(dn),
        .loop_search_done_i(done), .irq_o(irq));
    function automatic logic [31:0] rnd();
        st = st ^ (st << 13);
        st = st ^ (st >> 17);
        st = st ^ (st << 5);
        return st;
    endfunction
    // Mode bits are {source select, data invert, force-ones release}
    function automatic logic tx_exp(input logic [2:0] m, input logic h, input logic b);
        return m[0] ? ((m[2] ? b : h) ^ m[1]) : 1'b1;
    endfunction
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
            output logic [31:0] r);
        @(posedge clk_i);
        cyc <= 1'b1;
        we <= w;
        adr <= a;
        wd <= d;
        @(posedge clk_i);
        // No answer time assumed; only the watchdog ends a hung wait
        while (ack !== 1'b1) @(posedge clk_i);
        r = rd;
        cyc <= 1'b0;
    endtask
    // Second strobe after a write, so the new settings are in force
    task automatic pulses(input logic rx);
        for (int k = 0; k < 2; k++) begin
            @(posedge clk_i);
            while ((rx ? rxv : treq) !== 1'b1) @(posedge clk_i);
        end
    endtask
    task automatic results();
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    initial begin
        #100000;
        bad_count++;
        results();
    end
    initial begin
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        bus(1'b0, 8'h00, 32'h0, q);
        check("rx_ctrl", q, {16'h0, tdm_port_pkg::RX_CTRL_RESET});
        bus(1'b0, 8'h04, 32'h0, q);
        check("tx_ctrl", q, {16'h0, tdm_port_pkg::TX_CTRL_RESET});
        check("tx_pin", {31'h0, txd}, 32'h1);
        $display("reset test done");
        for (int i = 0; i < 4; i++) begin
            v = rnd();
            bus(1'b1, 8'h00, v, q);
            bus(1'b1, 8'h04, v, q);
            bus(1'b1, 8'h08, ~v, q);
            bus(1'b0, 8'h08, 32'h0, q);
            check("unmapped", q, 32'h0);
            bus(1'b0, 8'h00, 32'h0, q);
            check("rx_ctrl", q, v & {16'h0, tdm_port_pkg::RX_WR_MASK});
            bus(1'b0, 8'h04, 32'h0, q);
            check("tx_ctrl", q, v & {16'h0, tdm_port_pkg::TX_WR_MASK});
        end
        $display("register test done");
        bus(1'b1, 8'h00, 32'h0, q);
        run <= 1'b1;
        for (int m = 0; m < 8; m++) begin
            v = rnd();
            hb <= v[0];
            bb <= v[1];
            bus(1'b1, 8'h04, {20'h0, m[2], 2'b01, 5'h00, m[0], 1'b0, m[1], 1'b0}, q);
            pulses(1'b0);
            repeat (2) @(posedge clk_i);
            check("tx_pin", {31'h0, txd}, {31'h0, tx_exp(m[2:0], v[0], v[1])});
        end
        $display("transmit test done");
        for (int i = 0; i < 4; i++) begin
            v = rnd();
            lvl <= v[0];
            bus(1'b1, 8'h00, {22'h0, 1'b1, 7'h00, i[0], 1'b0}, q);
            pulses(1'b1);
            check("rx_bit", {31'h0, rxb}, {31'h0, v[0] ^ i[0]});
        end
        $display("receive test done");
        // Sync every 193 clocks against 256-clock frames: the second sync is misaligned
        frame <= 11'h0C1;
        bus(1'b1, 8'h04, 32'h4078, q);
        bus(1'b1, 8'h00, 32'h4040, q);
        while (fs !== 1'b1) @(posedge clk_i);
        check("rx_index", {22'h0, idx}, 32'h0);
        check("irq_first", {31'h0, irq}, 32'h0);
        while (irq !== 1'b1) @(posedge clk_i);
        // Transmit start trails by its two-clock sync lead
        repeat (40) @(posedge clk_i);
        bus(1'b0, 8'h00, 32'h0, q);
        check("rx_frame_alignment_change", q, 32'hC040);
        bus(1'b0, 8'h04, 32'h0, q);
        check("tx_frame_alignment_change", q, 32'hC078);
        repeat (2) @(posedge clk_i);
        check("irq_clear", {31'h0, irq}, 32'h0);
        bus(1'b0, 8'h00, 32'h0, q);
        check("rx_cleared", q, 32'h4040);
        frame <= 11'h000;
        run <= 1'b0;
        $display("framing test done");
        bus(1'b1, 8'h00, 32'h8, q);
        bus(1'b1, 8'h00, 32'h0, q);
        for (n = 0; n < 10 && lrst !== 1'b1; n++) @(posedge clk_i);
        check("det_reset", {31'h0, lrst}, 32'h1);
        done <= 1'b1;
        bus(1'b0, 8'h00, 32'h0, q);
        check("timeout", q, 32'h1000);
        up <= 1'b1;
        @(posedge clk_i);
        up <= 1'b0;
        bus(1'b0, 8'h00, 32'h0, q);
        check("loop_up", q, 32'h2000);
        dn <= 1'b1;
        @(posedge clk_i);
        dn <= 1'b0;
        bus(1'b0, 8'h00, 32'h0, q);
        check("loop_down", q, 32'h1000);
        $display("detector test done");
        results();
    end
endmodule
